/* File: gd_params.svh */
/*
  register offsets, reset values, field positions and timing figures
  of the gate driver protection configuration block.
  assumes: included by bare name wherever these values are needed.
*/
`ifndef GD_PARAMS_SVH
`define GD_PARAMS_SVH

// register offsets on the serial register port
`define GD_ADDR_LS 4'h4
`define GD_ADDR_OC 4'h5
`define GD_ADDR_CS 4'h6

// per-register reset values
`define GD_RST_LS 11'h7ff
`define GD_RST_OC 11'h159
`define GD_RST_CS 11'h283

// field positions in the current sense register
`define GD_CS_INSEL_BIT 10
`define GD_CS_LSREF_BIT 8

// clock period and times in ns, base figure of each code ladder
`define GD_CLK_NS 100
`define GD_DEG_STEP_NS 2000
`define GD_DEAD_BASE_NS 50
`define GD_PEAK_BASE_NS 500
`define GD_RETRY_LONG_NS 4000000
`define GD_RETRY_SHORT_NS 50000

// least time to whole cycles, never below one
`define GD_CYC_UP(ns) ((((ns) + `GD_CLK_NS - 1) / `GD_CLK_NS) > 0 ? \
  (((ns) + `GD_CLK_NS - 1) / `GD_CLK_NS) : 1)

`endif

/* File: gd_pkg.sv */
/*
  types of the gate driver protection configuration block.
  assumes: field layouts match the 11-bit register words.
*/
package gd_pkg;

  // overcurrent response codes
  typedef enum logic [1:0] {
    OC_LATCH = 2'b00,
    OC_RETRY = 2'b01,
    OC_REPORT = 2'b10,
    OC_IGNORE = 2'b11
  } gd_oc_resp_t;

  // fault state
  typedef enum logic [1:0] {
    ST_OK = 2'b00,
    ST_LATCHED = 2'b01,
    ST_RETRY = 2'b10
  } gd_fault_st_t;

  typedef struct packed {
    logic perCycleFaultClear;
    logic [1:0] peakCurrentDuration;
    logic [3:0] lowsideSourceStrength;
    logic [3:0] lowsideSinkStrength;
  } gd_ls_cfg_t;

  typedef struct packed {
    logic faultRetryWait;
    logic [1:0] deadTime;
    gd_oc_resp_t overcurrentResponse;
    logic [1:0] overcurrentFilterTime;
    logic [3:0] drainSourceTripLevel;
  } gd_oc_cfg_t;

  // ampOffsetShort[2] is amp a, [0] is amp c
  typedef struct packed {
    logic ampInputSelect;
    logic refHalf;
    logic lowsideMeasureRef;
    logic [1:0] ampGainSelect;
    logic shuntFaultDisable;
    logic [2:0] ampOffsetShort;
    logic [1:0] shuntTripLevel;
  } gd_cs_cfg_t;

  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] stable;
    logic [6:0] cnt;
    logic accepted;
  } gd_filt_st_t;

  typedef struct packed {
    gd_ls_cfg_t ls;
    gd_oc_cfg_t oc;
    gd_cs_cfg_t cs;
    logic [10:0] rdData;
    logic [2:0] pwmMeta;
    logic [2:0] pwmSync;
    logic [2:0] pwmPrev;
    gd_fault_st_t state;
    logic [15:0] retryCnt;
    logic faultAct;
    logic faultRep;
    logic [2:0][2:0] dtCnt;
    logic [2:0] gateHi;
    logic [2:0] gateLo;
    logic [2:0][5:0] peakCnt;
    logic [2:0] peakAct;
  } gd_main_st_t;

endpackage : gd_pkg

/* File: gd_oc_filter.sv */
/*
  overcurrent input synchroniser and deglitch filter.
  assumes: raw comparator levels arrive asynchronously on pins.
*/
`timescale 1ns/1ps
`include "gd_params.svh"

module gd_oc_filter (
  input wire logic clk, // 10 MHz clock
  input wire logic reset_n, // async reset
  input wire logic [5:0] ocRaw, // raw comparator levels
  input wire logic [5:0] ocMask, // per-input enable
  input wire logic [6:0] holdCycles, // persistence needed
  output logic ocAccepted // filtered overcurrent level
);

  gd_pkg::gd_filt_st_t q;
  gd_pkg::gd_filt_st_t d;
  logic hit;

  // two-stage sync, then count persistence of any enabled input
  always_comb begin
    d = q;
    d.meta = ocRaw;
    d.stable = q.meta;
    hit = |(q.stable & ocMask);
    if (!hit) begin
      d.cnt = 7'h00;
      d.accepted = 1'b0;
    end else begin
      if (q.cnt != 7'h7f) begin
        d.cnt = q.cnt + 7'h01;
      end
      d.accepted = ({1'b0, q.cnt} + 8'h01) >= {1'b0, holdCycles}; // R9
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ocAccepted = q.accepted;

  chk_filter_drop: assert property (@(posedge clk) disable iff (!reset_n)
    !hit |=> !ocAccepted) else $error("filter kept a dropped input"); // R9

endmodule : gd_oc_filter

/* File: gd_protection_config.sv */
/*
  gate driver protection configuration: three 11-bit registers on the
  serial register port, overcurrent fault handling, dead time and
  low-side peak drive windows.
  assumes: the serial frame logic decodes frames into one-cycle write
  strobes on clk; pwm and comparator inputs are asynchronous pins.
*/
// How it works
// R1: with per-cycle clear in retry mode, the next pwm input clears faults.
// R2: peak drive window lasts 500, 1000, 2000 or 4000 ns; reset 11.
// R3: retry wait is 4 ms when clear, 50 us when set.
// R4: dead time between complementary switches 50, 100, 200, 400 ns; code 00 gives one 100 ns cycle here.
// R5: mode 00 latches the fault until explicitly cleared.
// R6: mode 01 fault clears itself after the retry wait.
// R7: mode 10 only reports; outputs keep running.
// R8: mode 11 ignores overcurrent entirely.
// R9: deglitch needs 2, 4, 6 or 8 us persistence; reset 01.
// R10: writing amp input select 1 also forces low-side reference to 1.
// R11: reference halving bit selects full or half reference; reset 1.
// R12: low-side reference bit picks negative or positive shunt node.
// R13: amp gain 5, 10, 20 or 40 V/V; reset 10.
// R14: shunt fault disable bit suppresses shunt overcurrent faults.
// R15: each offset short bit shorts its amplifier inputs.
// R16: shunt trip level 0.25, 0.5, 0.75 or 1 V; reset 11.
// R17: current sense register exists only when amplifiers are fitted.
// R18: low-side source and sink strength, four bits each, reset 1111.
// R19: drain-source trip level four bits, reset 1001.
// R20: registers are 11 bits, read back as written, reset to defaults.
`timescale 1ns/1ps
`include "gd_params.svh"

module gd_protection_config #(
  parameter bit HAS_AMPS = 1'b1,
  parameter int RETRY_LONG_CYC = `GD_CYC_UP(`GD_RETRY_LONG_NS)
) (
  input wire logic clk, // 10 MHz clock
  input wire logic reset_n, // async reset
  input wire logic regWrite, // write strobe
  input wire logic [3:0] regAddr, // register offset
  input wire logic [10:0] regWrData, // write word
  output logic [10:0] regRdData, // read word
  input wire logic [2:0] pwmIn, // per-phase pwm pins
  input wire logic [2:0] dsOcRaw, // drain-source comparators
  input wire logic [2:0] shuntOcRaw, // shunt comparators
  input wire logic faultClear, // clear pulse
  output gd_pkg::gd_ls_cfg_t lsCfg, // low-side drive setup
  output gd_pkg::gd_oc_cfg_t ocCfg, // protection setup
  output gd_pkg::gd_cs_cfg_t csCfg, // amplifier setup
  output logic [2:0] gateHigh, // high-side gate on
  output logic [2:0] gateLow, // low-side gate on
  output logic [2:0] peakActive, // low-side peak current
  output logic faultActive, // outputs shut down
  output logic faultReport // overcurrent reported
);

  localparam int RETRY_SHORT_CYC = `GD_CYC_UP(`GD_RETRY_SHORT_NS);
  localparam int DEG_STEP_CYC = `GD_CYC_UP(`GD_DEG_STEP_NS);

  localparam gd_pkg::gd_main_st_t RST = '{
    ls: gd_pkg::gd_ls_cfg_t'(`GD_RST_LS),
    oc: gd_pkg::gd_oc_cfg_t'(`GD_RST_OC),
    cs: gd_pkg::gd_cs_cfg_t'(`GD_RST_CS),
    state: gd_pkg::ST_OK,
    default: '0
  };

  gd_pkg::gd_main_st_t q;
  gd_pkg::gd_main_st_t d;
  logic ocAccepted;
  logic pwmEdge;
  logic ocEvent;
  logic shut;
  logic [2:0] deadLoad;
  logic [5:0] peakLoad;
  logic [6:0] holdCycles;
  logic [5:0] ocMask;
  gd_pkg::gd_oc_resp_t mode;

  // dead time code to cycles, less one for the load
  function automatic logic [2:0] dead_load(input logic [1:0] code);
    int cyc;
    cyc = `GD_CYC_UP(`GD_DEAD_BASE_NS << code);
    return 3'(cyc - 1);
  endfunction : dead_load

  // peak drive code to cycles
  function automatic logic [5:0] peak_cycles(input logic [1:0] code);
    int cyc;
    cyc = `GD_CYC_UP(`GD_PEAK_BASE_NS << code);
    return 6'(cyc);
  endfunction : peak_cycles

  // filter settings from the protection and sense registers
  always_comb begin
    holdCycles = 7'((int'(q.oc.overcurrentFilterTime) + 1) * DEG_STEP_CYC); // R9
    ocMask[2:0] = 3'b111;
    ocMask[5:3] = {3{HAS_AMPS && !q.cs.shuntFaultDisable}}; // R14
  end

  gd_oc_filter u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .ocRaw({shuntOcRaw, dsOcRaw}),
    .ocMask(ocMask),
    .holdCycles(holdCycles),
    .ocAccepted(ocAccepted)
  );

  // next state of the whole block
  always_comb begin
    d = q;
    mode = q.oc.overcurrentResponse;
    deadLoad = dead_load(q.oc.deadTime);
    peakLoad = peak_cycles(q.ls.peakCurrentDuration);
    d.pwmMeta = pwmIn;
    d.pwmSync = q.pwmMeta;
    d.pwmPrev = q.pwmSync;
    pwmEdge = |(q.pwmSync ^ q.pwmPrev);
    shut = q.state != gd_pkg::ST_OK;

    // register writes, whole words
    if (regWrite) begin
      if (regAddr == `GD_ADDR_LS) begin
        d.ls = gd_pkg::gd_ls_cfg_t'(regWrData); // R20
      end else if (regAddr == `GD_ADDR_OC) begin
        d.oc = gd_pkg::gd_oc_cfg_t'(regWrData); // R20
      end else if (regAddr == `GD_ADDR_CS && HAS_AMPS) begin // R17
        d.cs = gd_pkg::gd_cs_cfg_t'(regWrData); // R20
        if (regWrData[`GD_CS_INSEL_BIT]) begin
          d.cs.lowsideMeasureRef = 1'b1; // R10
        end
      end
    end

    // read word, one cycle after the address
    if (regAddr == `GD_ADDR_LS) begin
      d.rdData = q.ls;
    end else if (regAddr == `GD_ADDR_OC) begin
      d.rdData = q.oc;
    end else if (regAddr == `GD_ADDR_CS && HAS_AMPS) begin // R17
      d.rdData = q.cs;
    end else begin
      d.rdData = 11'h000;
    end

    // reporting: new event wins over the clear
    ocEvent = ocAccepted && mode != gd_pkg::OC_IGNORE; // R8
    d.faultRep = (q.faultRep && !faultClear) || ocEvent; // R7

    // fault state machine
    case (q.state)
      gd_pkg::ST_OK: begin
        if (ocAccepted && mode == gd_pkg::OC_LATCH) begin
          d.state = gd_pkg::ST_LATCHED; // R5
        end else if (ocAccepted && mode == gd_pkg::OC_RETRY) begin
          d.state = gd_pkg::ST_RETRY; // R6
          if (q.oc.faultRetryWait) begin
            d.retryCnt = 16'(RETRY_SHORT_CYC - 1); // R3
          end else begin
            d.retryCnt = 16'(RETRY_LONG_CYC - 1); // R3
          end
        end
      end
      gd_pkg::ST_LATCHED: begin
        if (faultClear) begin
          d.state = gd_pkg::ST_OK; // R5
        end
      end
      gd_pkg::ST_RETRY: begin
        if (faultClear) begin
          d.state = gd_pkg::ST_OK;
        end else if (q.ls.perCycleFaultClear && pwmEdge) begin
          d.state = gd_pkg::ST_OK; // R1
        end else if (q.retryCnt == 16'h0000) begin
          d.state = gd_pkg::ST_OK; // R6
        end else begin
          d.retryCnt = q.retryCnt - 16'h0001;
        end
      end
      default: begin
        d.state = gd_pkg::ST_OK;
      end
    endcase
    d.faultAct = d.state != gd_pkg::ST_OK;

    // per phase: dead time gap, shutdown, low-side peak window
    for (int i = 0; i < 3; i++) begin
      if (q.pwmSync[i] != q.pwmPrev[i]) begin
        d.dtCnt[i] = deadLoad; // R4
        d.gateHi[i] = 1'b0;
        d.gateLo[i] = 1'b0;
      end else if (q.dtCnt[i] != 3'h0) begin
        d.dtCnt[i] = q.dtCnt[i] - 3'h1; // R4
        d.gateHi[i] = 1'b0;
        d.gateLo[i] = 1'b0;
      end else begin
        d.gateHi[i] = q.pwmSync[i] && !shut; // R7
        d.gateLo[i] = !q.pwmSync[i] && !shut;
      end
      if (d.gateLo[i] != q.gateLo[i]) begin
        d.peakCnt[i] = peakLoad; // R2
      end else if (q.peakCnt[i] != 6'h00) begin
        d.peakCnt[i] = q.peakCnt[i] - 6'h01; // R2
      end
      d.peakAct[i] = d.peakCnt[i] != 6'h00;
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= RST; // R20
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign regRdData = q.rdData;
  assign lsCfg = q.ls; // R18
  assign ocCfg = q.oc; // R19
  assign csCfg = q.cs; // R11 R12 R13 R15 R16
  assign gateHigh = q.gateHi;
  assign gateLow = q.gateLo;
  assign peakActive = q.peakAct;
  assign faultActive = q.faultAct;
  assign faultReport = q.faultRep;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_dead_gap;
    !gateHigh[0] [*4];
  endsequence

  sequence s_peak_short;
    peakActive[0] [*5] ##1 !peakActive[0];
  endsequence

  chk_ls_readback: assert property ( // R20
    regWrite && regAddr == `GD_ADDR_LS ##1 regAddr == `GD_ADDR_LS
    |=> regRdData == $past(regWrData, 2))
    else $error("low-side register did not read back");

  chk_insel_forces: assert property ( // R10
    regWrite && regAddr == `GD_ADDR_CS && regWrData[`GD_CS_INSEL_BIT]
    && HAS_AMPS |=> csCfg.lowsideMeasureRef && csCfg.ampInputSelect)
    else $error("input select did not force low-side reference");

  chk_no_amp_read: assert property ( // R17
    !HAS_AMPS && regAddr == `GD_ADDR_CS |=> regRdData == 11'h000)
    else $error("absent sense register read nonzero");

  chk_latch_hold: assert property ( // R5
    q.state == gd_pkg::ST_LATCHED && !faultClear
    |=> faultActive && q.state == gd_pkg::ST_LATCHED)
    else $error("latched fault released without clear");

  chk_retry_short: assert property ( // R3
    q.state == gd_pkg::ST_OK && ocAccepted && mode == gd_pkg::OC_RETRY
    && q.oc.faultRetryWait && !q.ls.perCycleFaultClear
    |=> faultActive [*8] ##[1:500] !faultActive)
    else $error("short retry wait not honoured");

  chk_cbc_clear: assert property ( // R1
    q.state == gd_pkg::ST_RETRY && q.ls.perCycleFaultClear && pwmEdge
    |=> q.state == gd_pkg::ST_OK)
    else $error("per-cycle clear missed a pwm edge");

  chk_report_only: assert property ( // R7
    q.state == gd_pkg::ST_OK && mode == gd_pkg::OC_REPORT && ocAccepted
    |=> faultReport && !faultActive)
    else $error("report-only mode acted or did not report");

  chk_ignore_mode: assert property ( // R8
    mode == gd_pkg::OC_IGNORE && !faultReport && q.state == gd_pkg::ST_OK
    |=> !faultReport && !faultActive)
    else $error("ignore mode reported an overcurrent");

  chk_dead_gap: assert property ( // R4
    $fell(gateLow[0]) && ocCfg.deadTime == 2'b11 && !$changed(pwmIn[0])
    |-> s_dead_gap)
    else $error("dead time shorter than 400 ns");

  chk_peak_window: assert property ( // R2
    $changed(gateLow[0]) && lsCfg.peakCurrentDuration == 2'b00
    ##1 !$changed(gateLow[0]) [*4] |-> peakActive[0])
    else $error("peak window ended early");

  chk_peak_len: assert property ( // R2
    $changed(gateLow[0]) && lsCfg.peakCurrentDuration == 2'b00
    && !$changed(pwmIn[0]) |-> s_peak_short)
    else $error("peak window not 500 ns");

  chk_shunt_off: assert property ( // R14
    csCfg.shuntFaultDisable && u_filter.q.stable[2:0] == 3'h0
    |=> !ocAccepted)
    else $error("shunt input enabled while disabled");

  // gate, fault and register checks across all phases
  chk_no_overlap: assert property ( // R4
    (gateHigh & $past(gateLow)) == 3'h0
    && (gateLow & $past(gateHigh)) == 3'h0)
    else $error("complementary gates without a gap");

  chk_shut_gates: assert property ( // R5
    faultActive |=> gateHigh == 3'h0 && gateLow == 3'h0)
    else $error("gates on during a fault shutdown");

  chk_latch_clear: assert property ( // R5
    q.state == gd_pkg::ST_LATCHED && faultClear |=> q.state == gd_pkg::ST_OK)
    else $error("latched fault kept after clear");

  chk_report_sticky: assert property ( // R7
    faultReport && !faultClear |=> faultReport)
    else $error("report dropped without a clear");

  chk_fault_reports: assert property ( // R6
    $rose(faultActive) |-> faultReport)
    else $error("fault shutdown without a report");

  chk_no_cause: assert property ( // R9
    q.state == gd_pkg::ST_OK && !ocAccepted
    |=> !faultActive)
    else $error("fault without an accepted overcurrent");

  chk_retry_long: assert property ( // R3
    q.state == gd_pkg::ST_OK && ocAccepted && mode == gd_pkg::OC_RETRY
    && !q.oc.faultRetryWait |=> q.retryCnt == 16'(RETRY_LONG_CYC - 1))
    else $error("long retry wait not loaded");

  chk_peak_follow: assert property ( // R2
    ((gateLow ^ $past(gateLow)) & ~peakActive) == 3'h0)
    else $error("low-side change without a peak window");

  chk_cs_absent: assert property ( // R17
    !HAS_AMPS |-> csCfg == gd_pkg::gd_cs_cfg_t'(`GD_RST_CS))
    else $error("absent sense register changed");

  chk_oc_write: assert property ( // R20
    regWrite && regAddr == `GD_ADDR_OC |=> ocCfg == $past(regWrData))
    else $error("protection register write did not land");

endmodule : gd_protection_config

/* File: gd_host_model.sv */
/*
  host side of the serial register port: single word writes and
  reads of the configuration registers.
  assumes: the design takes writes and addresses on rising clk.
*/
`timescale 1ns/1ps

module gd_host_model (
  input wire logic clk, // register port clock
  input wire logic [10:0] regRdData, // read word
  output logic regWrite, // write strobe
  output logic [3:0] regAddr, // register offset
  output logic [10:0] regWrData // write word
);
  // idle port before the first access
  initial begin
    regWrite = 1'b0;
    regAddr = 4'h0;
    regWrData = 11'h000;
  end

  // one-cycle write pulse, launched at the falling edge
  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrite = 1'b0;
    regWrData = ~d; // released data never shows the old word
  endtask : wr

  // address held over the registered read latency
  task automatic rd(input logic [3:0] a, output logic [10:0] d);
    @(negedge clk);
    regAddr = a;
    @(negedge clk);
    @(negedge clk);
    d = regRdData;
  endtask : rd
endmodule : gd_host_model

/* File: gd_protection_config_tb_top.sv */
/*
  testbench: register reset values and readback, dead time, peak
  window and the four overcurrent responses.
  assumes: gd_pkg, gd_params.svh and gd_host_model are compiled.
*/
`timescale 1ns/1ps
`include "gd_params.svh"
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin \
  errors++; $display("BAD t=%0t got %h exp %h", $time, a, e); end end
`define WAIT(c, l) begin n = 0; while (!(c) && n < l) begin \
  @(negedge clk); n++; end end

module gd_protection_config_tb_top;
  logic clk, reset_n, regWrite, faultClear, faultActive, faultReport;
  logic [3:0] regAddr;
  logic [10:0] regWrData, regRdData, rv, d;
  logic [2:0] pwmIn, dsOcRaw, shuntOcRaw, gateHigh, gateLow, peakActive;
  gd_pkg::gd_ls_cfg_t lsCfg;
  gd_pkg::gd_oc_cfg_t ocCfg;
  gd_pkg::gd_cs_cfg_t csCfg;
  gd_pkg::gd_cs_cfg_t noAmpCs;
  logic [10:0] noAmpRd;
  int errors, totalChecks, n;
  int deadCyc[4] = '{1, 1, 2, 4};

  gd_protection_config #(.HAS_AMPS(1'b1), .RETRY_LONG_CYC(600)) dut_u (
    .clk(clk), .reset_n(reset_n), .regWrite(regWrite),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .pwmIn(pwmIn), .dsOcRaw(dsOcRaw), .shuntOcRaw(shuntOcRaw),
    .faultClear(faultClear), .lsCfg(lsCfg), .ocCfg(ocCfg),
    .csCfg(csCfg), .gateHigh(gateHigh), .gateLow(gateLow),
    .peakActive(peakActive), .faultActive(faultActive),
    .faultReport(faultReport)
  );

  // variant without amplifiers on the same port and pins
  gd_protection_config #(.HAS_AMPS(1'b0), .RETRY_LONG_CYC(600)) noamp_u (
    .clk(clk), .reset_n(reset_n), .regWrite(regWrite),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(noAmpRd),
    .pwmIn(pwmIn), .dsOcRaw(dsOcRaw), .shuntOcRaw(shuntOcRaw),
    .faultClear(faultClear), .lsCfg(), .ocCfg(), .csCfg(noAmpCs),
    .gateHigh(), .gateLow(), .peakActive(), .faultActive(),
    .faultReport()
  );

  gd_host_model host_u (
    .clk(clk), .regRdData(regRdData), .regWrite(regWrite),
    .regAddr(regAddr), .regWrData(regWrData)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // counts and verdict, the single end of the run
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : giveVerdict

  // overcurrent on one input until reported or 80 cycles pass, then released
  task automatic fire(input bit shunt);
    @(negedge clk);
    if (shunt) shuntOcRaw = 3'b001;
    else dsOcRaw = 3'b001;
    `WAIT(faultReport === 1'b1, 80)
    dsOcRaw = 3'b000;
    shuntOcRaw = 3'b000;
    // let the synchroniser and filter drain before the next write
    repeat (4) @(negedge clk);
  endtask : fire

  // fault clear pulse and settle
  task automatic clearF;
    @(negedge clk);
    faultClear = 1'b1;
    @(negedge clk);
    faultClear = 1'b0;
    repeat (4) @(negedge clk);
  endtask : clearF

  // main sequence
  initial begin
    reset_n = 1'b0;
    faultClear = 1'b0;
    pwmIn = 3'b000;
    dsOcRaw = 3'b000;
    shuntOcRaw = 3'b000;
    errors = 0;
    totalChecks = 0;
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    `CHK(lsCfg, `GD_RST_LS)
    `CHK(ocCfg, `GD_RST_OC)
    `CHK(csCfg, `GD_RST_CS)
    host_u.rd(4'h4, rv);
    `CHK(rv, 11'h7ff)
    host_u.rd(4'h5, rv);
    `CHK(rv, 11'h159)
    host_u.rd(4'h6, rv);
    `CHK(rv, 11'h283)
    $display("reset values done");
    // readback, amp input select forcing the reference bit
    for (int a = 4; a <= 6; a++) begin
      for (int p = 0; p < 3; p++) begin
        d = (p == 0) ? 11'h2aa : (p == 1) ? 11'h455 : 11'h000;
        host_u.wr(a[3:0], d);
        host_u.rd(a[3:0], rv);
        `CHK(rv, (a == 6 && d[10]) ? (d | 11'h100) : d)
      end
    end
    host_u.wr(4'h7, 11'h7ff);
    host_u.rd(4'h7, rv);
    `CHK(rv, 11'h000)
    host_u.rd(4'h6, rv);
    `CHK(rv, 11'h000)
    `CHK(noAmpRd, 11'h000)
    host_u.wr(4'h6, 11'h2aa);
    `CHK(csCfg.refHalf, 1'b1)
    `CHK(csCfg.lowsideMeasureRef, 1'b0)
    `CHK(csCfg.ampGainSelect, 2'b10)
    `CHK(csCfg.ampOffsetShort, 3'b010)
    `CHK(csCfg.shuntTripLevel, 2'b10)
    `CHK(noAmpCs, `GD_RST_CS)
    $display("readback done");
    // dead time and peak window for every code
    for (int k = 0; k < 4; k++) begin
      host_u.wr(4'h5, {1'b0, k[1:0], 2'b11, 2'b00, 4'h9});
      host_u.wr(4'h4, {1'b0, k[1:0], 8'hff});
      @(negedge clk);
      pwmIn = 3'b111;
      `WAIT(gateLow[0] === 1'b0, 20)
      `WAIT(gateHigh[0] === 1'b1, 20)
      `CHK(n, deadCyc[k])
      repeat (50) @(negedge clk);
      pwmIn = 3'b000;
      `WAIT(gateLow[0] === 1'b1, 20)
      `WAIT(peakActive[0] === 1'b0, 60)
      `CHK(n, 5 << k)
    end
    $display("gate timing done");
    // latched fault
    host_u.wr(4'h4, 11'h3ff);
    host_u.wr(4'h5, {1'b0, 2'b01, 2'b00, 2'b00, 4'h9});
    fire(1'b0);
    repeat (700) @(negedge clk);
    `CHK({faultActive, faultReport, gateLow}, 5'b11000)
    clearF();
    `CHK({faultActive, faultReport}, 2'b00)
    // short and long retry waits
    for (int t = 1; t >= 0; t--) begin
      host_u.wr(4'h5, {t[0], 2'b01, 2'b01, 2'b00, 4'h9});
      fire(1'b0);
      `CHK(faultActive, 1'b1)
      `WAIT(faultActive === 1'b0, 1000)
      `CHK(n >= (t ? 490 : 590) && n <= (t ? 505 : 605), 1'b1)
      clearF();
    end
    // per-cycle clear on the next pwm input
    host_u.wr(4'h4, 11'h7ff);
    fire(1'b0);
    pwmIn = 3'b111;
    `WAIT(faultActive === 1'b0, 10)
    `CHK(faultActive, 1'b0)
    pwmIn = 3'b000;
    clearF();
    $display("retry done");
    // report only, then ignore
    host_u.wr(4'h5, {1'b0, 2'b01, 2'b10, 2'b00, 4'h9});
    fire(1'b0);
    repeat (10) @(negedge clk);
    `CHK({faultActive, faultReport, gateLow[0]}, 3'b011)
    clearF();
    host_u.wr(4'h5, {1'b0, 2'b01, 2'b11, 2'b00, 4'h9});
    fire(1'b0);
    `CHK({faultActive, faultReport}, 2'b00)
    // shunt fault disabled, then enabled
    host_u.wr(4'h5, {1'b0, 2'b01, 2'b00, 2'b00, 4'h9});
    host_u.wr(4'h6, 11'h2a3);
    fire(1'b1);
    `CHK({faultActive, faultReport}, 2'b00)
    host_u.wr(4'h6, 11'h283);
    fire(1'b1);
    `CHK({faultActive, faultReport}, 2'b11)
    clearF();
    $display("fault modes done");
    // mid-run reset brings every register back to its default
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    `CHK({lsCfg, ocCfg, csCfg}, {`GD_RST_LS, `GD_RST_OC, `GD_RST_CS})
    host_u.rd(4'h5, rv);
    `CHK(rv, `GD_RST_OC)
    $display("mid-run reset done");
    giveVerdict();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    giveVerdict();
  end
endmodule : gd_protection_config_tb_top
